// [src/mfb_pkg.sv]
/*
 * Shared constants and types for the parallel muting safety logic.
 * Assumes a 100 MHz system clock and a logic execution cycle made by a divider.
 */
package mfb_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOGIC_CYCLE_US = 4000;
	localparam int TICK_CYCLES_DEF = (LOGIC_CYCLE_US * 1000) / CLK_PERIOD_NS;
	localparam int BELT_EXT_MS = 5000;
	localparam int BELT_EXT_TICKS = (BELT_EXT_MS * 1000) / LOGIC_CYCLE_US;
	localparam int BLINK_HZ = 2;
	localparam int BLINK_HALF_US = 1000000 / (2 * BLINK_HZ);
	localparam int BLINK_HALF_TICKS = BLINK_HALF_US / LOGIC_CYCLE_US;
	localparam int BLINK_W = 8;
	localparam int TMR_W = 16;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CFG_ADDR = 8'h00;
	localparam logic [7:0] REG_TOTAL_ADDR = 8'h04;
	localparam logic [7:0] REG_CONC_ADDR = 8'h08;
	localparam logic [7:0] REG_OVR_ADDR = 8'h0C;
	localparam logic [7:0] REG_STATUS_ADDR = 8'h10;
	localparam logic [7:0] CFG_RST = 8'h0F;
	localparam logic [TMR_W-1:0] TOTAL_RST = 16'h0FA0;
	localparam logic [TMR_W-1:0] CONC_RST = 16'h0064;
	localparam logic [TMR_W-1:0] OVR_RST = 16'h3A98;
	localparam logic [TMR_W-1:0] BELT_EXT = TMR_W'(BELT_EXT_TICKS);

	// Configuration bit positions.
	localparam int CFG_CONC_EN = 0;
	localparam int CFG_TOTAL_EN = 1;
	localparam int CFG_END_ESPE = 2;
	localparam int CFG_OVR_EN = 3;
	localparam int CFG_DIR_USED = 4;
	localparam int CFG_DIR_LO = 5;
	localparam int CFG_DIR_HI = 6;
	localparam int CFG_CONV_USED = 7;

	// Direction detection modes.
	localparam logic [1:0] DIR_BOTH = 2'h0;
	localparam logic [1:0] DIR_A_FIRST = 2'h1;
	localparam logic [1:0] DIR_B_FIRST = 2'h2;

	// Muting error causes.
	localparam int ERR_CONC = 0;
	localparam int ERR_TOTAL = 1;
	localparam int ERR_DIR = 2;
	localparam int ERR_SEQ = 3;
	localparam int ERR_GAP = 4;
	localparam int ERR_W = 5;

	// Pin vector positions.
	localparam int PIN_A1 = 0;
	localparam int PIN_A2 = 1;
	localparam int PIN_B1 = 2;
	localparam int PIN_B2 = 3;
	localparam int PIN_DIR = 4;
	localparam int PIN_ESPE = 5;
	localparam int PIN_OVR = 6;
	localparam int PIN_CONV = 7;
	localparam int PIN_RUN = 8;
	localparam int PIN_W = 9;

	// Muting controller states.
	typedef enum logic [8:0] {
		ST_STOP = 9'h001,
		ST_IDLE = 9'h002,
		ST_BLOCKED = 9'h004,
		ST_WAIT_CLEAR = 9'h008,
		ST_MUTE_FIRST = 9'h010,
		ST_MUTE_SECOND = 9'h020,
		ST_OVR_REQ = 9'h040,
		ST_OVERRIDE = 9'h080,
		ST_ERROR = 9'h100
	} mfb_state_type;

endpackage

// [src/mfb_timer.sv]
/*
 * Pausable saturating tick counter with a registered expiry flag.
 * Assumes tick_in is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module mfb_timer
	import mfb_pkg::*;
#(
	parameter int W = 16
)
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Control.
	input wire logic tick_in,
	input wire logic run_in,
	input wire logic clear_in,
	input wire logic [W-1:0] limit_in,
	// Result.
	output logic expired_out
);

	typedef struct packed {
		logic [W-1:0] count;
		logic expired;
	} mfb_tmr_vec_type;

	mfb_tmr_vec_type q_reg;
	mfb_tmr_vec_type q_next;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------

	// Count on ticks while running, hold while paused, restart on clear.
	always_comb
	begin
		q_next = q_reg;
		if (clear_in)
		begin
			q_next.count = '0;
		end
		else if (tick_in && run_in && (q_reg.count != {W{1'b1}}))
		begin
			q_next.count = W'(q_reg.count + 1'b1);
		end
		q_next.expired = !clear_in && (q_next.count >= limit_in);
	end

	// State register.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			q_reg <= '0;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	assign expired_out = q_reg.expired;

endmodule

// [src/mfb_parallel_muting.sv]
/*
 * Parallel muting safety logic with start-up handling, error latching,
 * override and a small register port for configuration and status.
 * Assumes sensor pins are asynchronous and that software writes the
 * configuration before Run is entered.
 */
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module mfb_parallel_muting
	import mfb_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register port.
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Sensor and command pins.
	input wire logic first_pair_sensor_one_in,
	input wire logic first_pair_sensor_two_in,
	input wire logic second_pair_sensor_one_in,
	input wire logic second_pair_sensor_two_in,
	input wire logic direction_enable_input_in,
	input wire logic espe_ossd_in,
	input wire logic override_in,
	input wire logic conveyor_in,
	input wire logic run_mode_in,
	// Safety outputs.
	output logic enable_out,
	output logic muting_status_out,
	output logic muting_lamp_out,
	output logic override_required_out,
	output logic muting_error_out,
	output logic fault_present_out
);

	localparam int DIV_W = $clog2(TICK_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_TICKS - 1);

	typedef struct packed {
		logic [PIN_W-1:0] sync1;
		logic [PIN_W-1:0] sync2;
		logic [DIV_W-1:0] div;
		logic tick;
		mfb_state_type state;
		logic first_is_b;
		logic [ERR_W-1:0] err;
		logic ext_used;
		logic ovr_prev;
		logic dir_prev;
		logic [BLINK_W-1:0] blink_cnt;
		logic blink;
		logic [7:0] cfg;
		logic [TMR_W-1:0] total_lim;
		logic [TMR_W-1:0] conc_lim;
		logic [TMR_W-1:0] ovr_lim;
		logic [31:0] rdata;
		logic enable;
		logic status;
		logic lamp;
		logic ovr_req;
		logic mute_err;
	} mfb_vec_type;

	mfb_vec_type q_reg;
	mfb_vec_type q_next;

	logic [PIN_W-1:0] pins;
	logic [1:0] pair_a;
	logic [1:0] pair_b;
	logic [1:0] first_pair;
	logic [1:0] second_pair;
	logic espe;
	logic belt_run;
	logic in_mute;
	logic total_run;
	logic total_clear;
	logic conc_run;
	logic conc_clear;
	logic ovr_run;
	logic ovr_clear;
	logic [TMR_W-1:0] total_limit;
	logic total_exp;
	logic conc_exp;
	logic ovr_exp;

	// ----------------------------------------------------------------
	// Decoded view of the synchronised pins
	// ----------------------------------------------------------------

	// Pins gathered for the synchroniser.
	assign pins = {run_mode_in, conveyor_in, override_in, espe_ossd_in,
		direction_enable_input_in, second_pair_sensor_two_in, second_pair_sensor_one_in,
		first_pair_sensor_two_in, first_pair_sensor_one_in};

	// Pair views follow the transport direction latched at cycle start.
	assign pair_a = {q_reg.sync2[PIN_A2], q_reg.sync2[PIN_A1]};
	assign pair_b = {q_reg.sync2[PIN_B2], q_reg.sync2[PIN_B1]};
	assign first_pair = q_reg.first_is_b ? pair_b : pair_a;
	assign second_pair = q_reg.first_is_b ? pair_a : pair_b;
	assign espe = q_reg.sync2[PIN_ESPE];
	assign in_mute = (q_reg.state == ST_MUTE_FIRST) || (q_reg.state == ST_MUTE_SECOND);

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------

	assign belt_run = !q_reg.cfg[CFG_CONV_USED] || q_reg.sync2[PIN_CONV];
	assign total_run = in_mute && belt_run;
	assign total_clear = !in_mute;
	assign total_limit = TMR_W'(q_reg.total_lim + (q_reg.ext_used ? BELT_EXT : '0));
	// Concurrency runs while a pair that should switch together is split.
	assign conc_run = belt_run && (((q_reg.state == ST_IDLE) && ((^pair_a) || (^pair_b)))
		|| ((q_reg.state == ST_MUTE_FIRST) && (^second_pair)));
	assign conc_clear = !conc_run && belt_run;
	assign ovr_run = (q_reg.state == ST_OVR_REQ) || (q_reg.state == ST_OVERRIDE);
	assign ovr_clear = (q_reg.state == ST_IDLE) || (q_reg.state == ST_STOP);

	// Total muting time.
	mfb_timer #(.W(TMR_W)) total_tmr (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.tick_in(q_reg.tick),
		.run_in(total_run),
		.clear_in(total_clear),
		.limit_in(total_limit),
		.expired_out(total_exp)
	);

	// Concurrency window.
	mfb_timer #(.W(TMR_W)) conc_tmr (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.tick_in(q_reg.tick),
		.run_in(conc_run),
		.clear_in(conc_clear),
		.limit_in(q_reg.conc_lim),
		.expired_out(conc_exp)
	);

	// Total override time.
	mfb_timer #(.W(TMR_W)) ovr_tmr (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.tick_in(q_reg.tick),
		.run_in(ovr_run),
		.clear_in(ovr_clear),
		.limit_in(q_reg.ovr_lim),
		.expired_out(ovr_exp)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Synchroniser, divider, register port, controller and outputs.
	always_comb
	begin
		logic [ERR_W-1:0] new_err;
		logic clr;
		logic start_a;
		logic start_b;
		logic dir_bad;
		logic all_low;
		logic any_on;
		logic mute_act;
		new_err = '0;
		clr = 1'b0;
		start_a = 1'b0;
		start_b = 1'b0;
		dir_bad = 1'b0;
		all_low = !(|pair_a) && !(|pair_b);
		any_on = !all_low;
		mute_act = 1'b0;
		q_next = q_reg;
		q_next.sync1 = pins;
		q_next.sync2 = q_reg.sync1;
		q_next.tick = (q_reg.div == DIV_LAST);
		q_next.div = q_next.tick ? '0 : DIV_W'(q_reg.div + 1'b1);
		q_next.rdata = '0;

		// Register writes and reads.
		if (reg_wr_in)
		begin
			if (reg_addr_in == REG_CFG_ADDR)
				q_next.cfg = reg_wdata_in[7:0];
			else if (reg_addr_in == REG_TOTAL_ADDR)
				q_next.total_lim = reg_wdata_in[TMR_W-1:0];
			else if (reg_addr_in == REG_CONC_ADDR)
				q_next.conc_lim = reg_wdata_in[TMR_W-1:0];
			else if (reg_addr_in == REG_OVR_ADDR)
				q_next.ovr_lim = reg_wdata_in[TMR_W-1:0];
		end
		if (reg_rd_in)
		begin
			if (reg_addr_in == REG_CFG_ADDR)
				q_next.rdata = {24'h000000, q_reg.cfg};
			else if (reg_addr_in == REG_TOTAL_ADDR)
				q_next.rdata = {16'h0000, q_reg.total_lim};
			else if (reg_addr_in == REG_CONC_ADDR)
				q_next.rdata = {16'h0000, q_reg.conc_lim};
			else if (reg_addr_in == REG_OVR_ADDR)
				q_next.rdata = {16'h0000, q_reg.ovr_lim};
			else if (reg_addr_in == REG_STATUS_ADDR)
				q_next.rdata = {11'h000, q_reg.state, q_reg.err, q_reg.ext_used,
					q_reg.enable, q_reg.status, q_reg.lamp, q_reg.ovr_req,
					q_reg.mute_err, q_reg.mute_err};
		end

		if (q_reg.tick)
		begin
			q_next.ovr_prev = q_reg.sync2[PIN_OVR];
			q_next.dir_prev = q_reg.sync2[PIN_DIR];
			dir_bad = q_reg.cfg[CFG_DIR_USED] && !q_reg.dir_prev;
			case (q_reg.state)
				ST_STOP:
				begin
					if (q_reg.sync2[PIN_RUN])
					begin
						if (espe && all_low)
							q_next.state = ST_IDLE;
						else if (espe)
							q_next.state = ST_WAIT_CLEAR;
						else if (any_on && q_reg.cfg[CFG_OVR_EN])
							q_next.state = ST_OVR_REQ;
						else
							q_next.state = ST_BLOCKED;
					end
				end
				ST_BLOCKED:
				begin
					if (espe)
						q_next.state = all_low ? ST_IDLE : ST_WAIT_CLEAR;
				end
				ST_WAIT_CLEAR:
				begin
					if (all_low)
						q_next.state = ST_IDLE;
					else if (!espe && q_reg.cfg[CFG_OVR_EN])
						q_next.state = ST_OVR_REQ;
					else if (!espe)
						new_err[ERR_SEQ] = 1'b1;
				end
				ST_IDLE:
				begin
					q_next.ext_used = 1'b0;
					start_a = (&pair_a) && !(|pair_b);
					start_b = (&pair_b) && !(|pair_a);
					if ((&pair_a) && (&pair_b))
						new_err[ERR_SEQ] = 1'b1;
					else if ((start_a && (q_reg.cfg[CFG_DIR_HI:CFG_DIR_LO] == DIR_B_FIRST))
						|| (start_b && (q_reg.cfg[CFG_DIR_HI:CFG_DIR_LO] == DIR_A_FIRST))
						|| ((start_a || start_b) && dir_bad))
						new_err[ERR_DIR] = 1'b1;
					else if (start_a || start_b)
					begin
						q_next.first_is_b = start_b;
						q_next.state = ST_MUTE_FIRST;
					end
					if (conc_exp && q_reg.cfg[CFG_CONC_EN])
						new_err[ERR_CONC] = 1'b1;
				end
				ST_MUTE_FIRST:
				begin
					if ((&first_pair) && (&second_pair))
						q_next.state = ST_MUTE_SECOND;
					else if (!(&first_pair))
						new_err[ERR_SEQ] = 1'b1;
					if (conc_exp && q_reg.cfg[CFG_CONC_EN])
						new_err[ERR_CONC] = 1'b1;
				end
				ST_MUTE_SECOND:
				begin
					if (!(&second_pair))
					begin
						if (|first_pair)
							new_err[ERR_GAP] = 1'b1;
						else
						begin
							clr = 1'b1;
							q_next.state = ST_IDLE;
						end
					end
					else if (q_reg.cfg[CFG_END_ESPE] && espe && !(|first_pair))
					begin
						clr = 1'b1;
						q_next.state = ST_WAIT_CLEAR;
					end
				end
				ST_OVR_REQ:
				begin
					if (q_reg.sync2[PIN_OVR] && !q_reg.ovr_prev)
					begin
						clr = 1'b1;
						q_next.state = ST_OVERRIDE;
					end
					else if (all_low && espe)
						q_next.state = ST_IDLE;
				end
				ST_OVERRIDE:
				begin
					if (all_low)
					begin
						clr = 1'b1;
						q_next.state = ST_IDLE;
					end
				end
				ST_ERROR:
				begin
					if (all_low && espe)
						q_next.state = ST_IDLE;
					else if (any_on && !espe && q_reg.cfg[CFG_OVR_EN])
						q_next.state = ST_OVR_REQ;
				end
				default:
				begin
					q_next.state = ST_STOP;
				end
			endcase

			if (in_mute && total_exp && q_reg.cfg[CFG_TOTAL_EN])
				new_err[ERR_TOTAL] = 1'b1;
			if (ovr_run && ovr_exp)
				new_err[ERR_TOTAL] = 1'b1;
			if (in_mute && !belt_run)
				q_next.ext_used = 1'b1;
			if (|new_err)
				q_next.state = ST_ERROR;
			q_next.err = (clr ? '0 : q_reg.err) | new_err;
			if (!q_reg.sync2[PIN_RUN])
			begin
				q_next.state = ST_STOP;
				q_next.err = '0;
			end

			// Blink runs only while override is requested.
			if (q_next.state != ST_OVR_REQ)
			begin
				q_next.blink_cnt = '0;
				q_next.blink = 1'b1;
			end
			else if (q_reg.blink_cnt == BLINK_LAST)
			begin
				q_next.blink_cnt = '0;
				q_next.blink = !q_reg.blink;
			end
			else
				q_next.blink_cnt = BLINK_W'(q_reg.blink_cnt + 1'b1);

			// muted first pair to far clear, or in override
			mute_act = (q_next.state == ST_MUTE_FIRST) || (q_next.state == ST_MUTE_SECOND)
				|| (q_next.state == ST_OVERRIDE);
			q_next.mute_err = |q_next.err;
			q_next.enable = !q_next.mute_err && (mute_act || (espe
				&& ((q_next.state == ST_IDLE) || (q_next.state == ST_WAIT_CLEAR))));
			q_next.status = mute_act && !q_next.mute_err;
			q_next.ovr_req = (q_next.state == ST_OVR_REQ) && q_next.blink;
			q_next.lamp = q_next.status || q_next.ovr_req;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// All state of the block, reset to constants.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			q_reg <= '0;
			q_reg.state <= ST_STOP;
			q_reg.cfg <= CFG_RST;
			q_reg.total_lim <= TOTAL_RST;
			q_reg.conc_lim <= CONC_RST;
			q_reg.ovr_lim <= OVR_RST;
		end
		else
		begin
			q_reg <= q_next;
		end
	end

	// Outputs come straight from the state register.
	assign reg_rdata_out = q_reg.rdata;
	assign enable_out = q_reg.enable;
	assign muting_status_out = q_reg.status;
	assign muting_lamp_out = q_reg.lamp;
	assign override_required_out = q_reg.ovr_req;
	assign muting_error_out = q_reg.mute_err;
	assign fault_present_out = q_reg.mute_err;

endmodule

// [sim/mfb_parallel_muting_chk.sv]
/*
 * Port-level assertions for the parallel muting block.
 * Assumes it is bound to the top module with the same TICK_CYCLES.
 */
`timescale 1ns/1ps
module mfb_parallel_muting_chk
	import mfb_pkg::*;
#(
	parameter int TICK_CYCLES = 10
)
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Watched inputs.
	input wire logic espe_ossd_in,
	input wire logic run_mode_in,
	// Watched outputs.
	input wire logic enable_out,
	input wire logic muting_status_out,
	input wire logic muting_lamp_out,
	input wire logic override_required_out,
	input wire logic muting_error_out,
	input wire logic fault_present_out
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	localparam int SETTLE = 2 * TICK_CYCLES + 4;
	logic [7:0] espe_low_reg;
	logic [7:0] run_low_reg;
	logic [4:0] outs;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Gather the tick-driven outputs except fault_present_out so one check covers them.
	assign outs = {enable_out, muting_status_out, muting_lamp_out, override_required_out,
		muting_error_out};
	// Count how long ESPE and Run have been low, saturating at the top.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			espe_low_reg <= 8'h00;
			run_low_reg <= 8'h00;
		end
		else
		begin
			espe_low_reg <= espe_ossd_in ? 8'h00 : espe_low_reg + {7'h00, espe_low_reg != 8'hFF};
			run_low_reg <= run_mode_in ? 8'h00 : run_low_reg + {7'h00, run_low_reg != 8'hFF};
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_FAULT_EQ_ERROR: assert property (
		fault_present_out == muting_error_out) else $error("Fault differs from error.");
	AST_ERROR_DROPS_ENABLE: assert property (
		muting_error_out |-> !enable_out) else $error("Enable high during error.");
	AST_ERROR_DROPS_STATUS: assert property (
		muting_error_out |-> !muting_status_out) else $error("Status high during error.");
	AST_LAMP_WITH_STATUS: assert property (
		muting_status_out |-> muting_lamp_out) else $error("Lamp off while muting.");
	AST_STATUS_GIVES_ENABLE: assert property (
		muting_status_out |-> enable_out) else $error("Enable low while muting.");
	AST_ESPE_LOW_NO_ENABLE: assert property (
		(espe_low_reg > SETTLE) && !muting_status_out |-> !enable_out)
		else $error("Enable high with ESPE interrupted and no muting.");
	AST_STOP_QUIET: assert property (
		(run_low_reg > SETTLE) |-> !enable_out && !muting_error_out && !muting_status_out)
		else $error("Outputs active in Stop.");
	AST_OUTS_PER_TICK: assert property (
		$changed(outs) |=> $stable(outs) [*8]) else $error("Outputs changed between ticks.");
	AST_OVR_REQ_NO_ENABLE: assert property (
		override_required_out |-> !enable_out && !muting_status_out)
		else $error("Enable or status high while override is requested.");
endmodule

// [sim/mfb_sensor_model.sv]
/*
 * Model of the light curtain OSSD and the muting sensors.
 * Assumes the bench requests a scene; sensors follow after lag_in + 1 cycles.
 */
`timescale 1ns/1ps
module mfb_sensor_model
	import mfb_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Requested scene.
	input wire logic [3:0] pattern_in,
	input wire logic espe_clear_in,
	input wire logic dir_in,
	input wire logic [3:0] lag_in,
	// Pins towards the block.
	output logic [3:0] sensors_out,
	output logic espe_out,
	output logic dir_out
);
	logic [3:0] wait_reg;
	// Sensors follow the request late, like a slowly moving object.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wait_reg <= 4'h0;
			sensors_out <= 4'h0;
			espe_out <= 1'b1;
			dir_out <= 1'b0;
		end
		else
		begin
			dir_out <= dir_in;
			if (pattern_in == sensors_out)
				wait_reg <= 4'h0;
			else if (wait_reg >= lag_in)
				sensors_out <= pattern_in;
			else
				wait_reg <= wait_reg + 4'h1;
			if (espe_clear_in || pattern_in == sensors_out)
				espe_out <= espe_clear_in;
		end
	end
endmodule

// [sim/mfb_parallel_muting_tb_top.sv]
/*
 * Self-checking bench for the parallel muting block.
 * Assumes a short logic cycle of TICK clocks and the sensor model beside it.
 */
`timescale 1ns/1ps
module mfb_parallel_muting_tb_top;
	import mfb_pkg::*;
	localparam int TICK = 10;
	localparam int STEP = 3 * TICK;
	logic sys_clk_in, sys_rst_in, reg_wr, reg_rd, override, conveyor, run_mode;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	logic [3:0] pattern, sensors, lag;
	logic espe_req, dir_req, espe_pin, dir_pin;
	logic enable, mstatus, lamp, ovr_req, merr, fault;
	int miscompares, cmp_count, cycles;

	mfb_parallel_muting #(.TICK_CYCLES(TICK)) mfb_parallel_muting_i (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .first_pair_sensor_one_in(sensors[0]),
		.first_pair_sensor_two_in(sensors[1]), .second_pair_sensor_one_in(sensors[2]),
		.second_pair_sensor_two_in(sensors[3]), .direction_enable_input_in(dir_pin),
		.espe_ossd_in(espe_pin), .override_in(override), .conveyor_in(conveyor),
		.run_mode_in(run_mode), .enable_out(enable), .muting_status_out(mstatus),
		.muting_lamp_out(lamp), .override_required_out(ovr_req), .muting_error_out(merr),
		.fault_present_out(fault));
	mfb_sensor_model mfb_sensor_model_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.pattern_in(pattern), .espe_clear_in(espe_req), .dir_in(dir_req), .lag_in(lag),
		.sensors_out(sensors), .espe_out(espe_pin), .dir_out(dir_pin));

	// Clock and a cycle ceiling against hangs.
	initial
	begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle();
		repeat (STEP) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic chk_state(input mfb_state_type s);
		reg_read(REG_STATUS_ADDR, rd_val);
		chk_word("state", {23'h000000, s}, {23'h000000, rd_val[20:12]});
	endtask
	task automatic scene(input logic [3:0] p, input logic e);
		@(posedge sys_clk_in);
		pattern <= p;
		espe_req <= e;
		settle();
	endtask
	task automatic restart(input logic [3:0] p, input logic e);
		@(posedge sys_clk_in);
		run_mode <= 1'b0;
		scene(p, e);
		@(posedge sys_clk_in);
		run_mode <= 1'b1;
		settle();
	endtask

	// Reset values, read-only status and an unmapped place.
	task automatic t_regs();
		reg_read(REG_CFG_ADDR, rd_val);
		chk_word("cfg", 32'h0000000F, rd_val);
		reg_read(REG_TOTAL_ADDR, rd_val);
		chk_word("total", 32'h00000FA0, rd_val);
		reg_read(REG_CONC_ADDR, rd_val);
		chk_word("conc", 32'h00000064, rd_val);
		reg_read(REG_OVR_ADDR, rd_val);
		chk_word("ovr", 32'h00003A98, rd_val);
		reg_read(8'h14, rd_val);
		chk_word("unmapped", 32'h00000000, rd_val);
		reg_write(REG_STATUS_ADDR, 32'hFFFFFFFF);
		reg_read(REG_STATUS_ADDR, rd_val);
		chk_word("status", 32'h00001000, rd_val);
	endtask
	// A clean cycle with a slow object and the curtain broken mid-way.
	task automatic t_normal();
		lag <= 4'h3;
		restart(4'h0, 1'b1);
		chk_bit("idle enable", 1'b1, enable);
		scene(4'h3, 1'b1);
		chk_bit("first pair", 1'b1, mstatus);
		chk_bit("lamp", 1'b1, lamp);
		scene(4'hF, 1'b0);
		chk_bit("handover", 1'b1, enable);
		scene(4'hC, 1'b0);
		chk_bit("second pair", 1'b1, mstatus);
		scene(4'h4, 1'b0);
		chk_bit("far clear", 1'b0, enable);
		scene(4'h0, 1'b1);
		chk_bit("back idle", 1'b1, enable);
		lag <= 4'h0;
	endtask
	// Sequence error, then clearing by a full valid cycle.
	task automatic t_error();
		scene(4'hF, 1'b1);
		chk_bit("seq error", 1'b1, merr);
		chk_bit("fault", 1'b1, fault);
		chk_bit("err enable", 1'b0, enable);
		scene(4'h0, 1'b1);
		chk_bit("error held", 1'b1, merr);
		scene(4'h3, 1'b1);
		scene(4'hF, 1'b0);
		scene(4'hC, 1'b0);
		scene(4'h4, 1'b0);
		chk_bit("error cleared", 1'b0, merr);
		scene(4'h0, 1'b1);
		chk_bit("clear enable", 1'b1, enable);
	endtask
	// Start-up cases: blocked, wait for clear, override and its timeout.
	task automatic t_startup();
		restart(4'h0, 1'b0);
		chk_state(ST_BLOCKED);
		scene(4'h0, 1'b1);
		chk_bit("unblocked", 1'b1, enable);
		restart(4'h3, 1'b1);
		chk_state(ST_WAIT_CLEAR);
		scene(4'h3, 1'b0);
		chk_state(ST_OVR_REQ);
		restart(4'h3, 1'b0);
		chk_state(ST_OVR_REQ);
		chk_bit("override request", 1'b1, ovr_req);
		@(posedge sys_clk_in);
		override <= 1'b1;
		settle();
		@(posedge sys_clk_in);
		override <= 1'b0;
		settle();
		chk_bit("override enable", 1'b1, enable);
		chk_bit("override status", 1'b1, mstatus);
		scene(4'h0, 1'b1);
		chk_state(ST_IDLE);
		reg_write(REG_OVR_ADDR, 32'h00000005);
		restart(4'h3, 1'b0);
		repeat (3) settle();
		chk_bit("override timeout", 1'b1, merr);
	endtask
	// Direction input and the fixed direction setting.
	task automatic t_direction();
		reg_write(REG_CFG_ADDR, 32'h0000003F);
		restart(4'h0, 1'b1);
		scene(4'h3, 1'b1);
		chk_bit("no direction", 1'b1, merr);
		restart(4'h0, 1'b1);
		@(posedge sys_clk_in);
		dir_req <= 1'b1;
		settle();
		scene(4'h3, 1'b1);
		chk_bit("direction ok", 1'b1, mstatus);
		restart(4'h0, 1'b1);
		scene(4'hC, 1'b1);
		chk_bit("wrong way", 1'b1, merr);
	endtask
	// A belt stop during muting keeps muting and spends the one-time extension.
	task automatic t_belt();
		reg_write(REG_CFG_ADDR, 32'h0000008F);
		restart(4'h0, 1'b1);
		scene(4'h3, 1'b1);
		@(posedge sys_clk_in);
		conveyor <= 1'b0;
		settle();
		chk_bit("belt stop muting", 1'b1, mstatus);
		reg_read(REG_STATUS_ADDR, rd_val);
		chk_bit("extension used", 1'b1, rd_val[6]);
		@(posedge sys_clk_in);
		conveyor <= 1'b1;
	endtask

	// Main sequence.
	initial
	begin
		sys_rst_in = 1'b1;
		{reg_wr, reg_rd, override, run_mode, dir_req} = 5'h00;
		{conveyor, espe_req} = 2'h3;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		pattern = 4'h0;
		lag = 4'h0;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (5) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_normal();
		t_error();
		t_startup();
		t_direction();
		t_belt();
		conclude();
	end
endmodule

bind mfb_parallel_muting mfb_parallel_muting_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .espe_ossd_in(espe_ossd_in),
	.run_mode_in(run_mode_in), .enable_out(enable_out), .muting_status_out(muting_status_out),
	.muting_lamp_out(muting_lamp_out), .override_required_out(override_required_out),
	.muting_error_out(muting_error_out), .fault_present_out(fault_present_out));
